// *** rtl/qsp_consts.svh ***
`ifndef QSP_CONSTS_SVH
`define QSP_CONSTS_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define OP_DEACT   8'h00
`define OP_SRST    8'h02
`define OP_HRST    8'h04
`define OP_NOP     8'h06
`define OP_ACT     8'h0e
`define OP_TXS     8'h40
`define OP_RXS     8'h42
`define OP_CLKS    8'h44
`define OP_CFG     8'h46
`define OP_CHEN    8'h4a
`define OP_RTD     8'h4d
`define OP_RTDC    8'h4f
`define OP_AISN    8'h50
`define OP_SIO     8'h52
`define OP_SDIR    8'h54
`define OP_OPF     8'h60
`define OP_IMSK    8'h6c
`define OP_OPC     8'h70
`define OP_REV     8'h73
`define OP_GX      8'h80
`define OP_GR      8'h82
`define OP_ZC      8'h84
`define OP_B1      8'h86
`define OP_XF      8'h88
`define OP_RF      8'h8a
`define OP_B2      8'h96
`define OP_ZF      8'h98
`define OP_ZI      8'h9a
`define OP_DEB     8'hc8
`define OP_TXPCM   8'hcd
`define OP_GK      8'he8
`define OP_RW_MASK 8'hfe

// ----------------------------------------------------------------------
// Data byte lengths: single-byte commands and coefficient blocks
// ----------------------------------------------------------------------
`define LEN_ONE    4'd1
`define LEN_GX     4'd2
`define LEN_GR     4'd2
`define LEN_ZC     4'd15
`define LEN_B1     4'd14
`define LEN_XF     4'd12
`define LEN_RF     4'd14
`define LEN_B2     4'd2
`define LEN_ZF     4'd10
`define LEN_ZI     4'd5

// ----------------------------------------------------------------------
// Register indices, fields and reset values
// ----------------------------------------------------------------------
`define C_TXS      3'd0
`define C_RXS      3'd1
`define C_AISN     3'd2
`define C_SIO      3'd3
`define C_SDIR     3'd4
`define C_OPF      3'd5
`define C_OPC      3'd6
`define NCREG      7
`define G_CLKS     3'd0
`define G_CFG      3'd1
`define G_CHEN     3'd2
`define G_IMSK     3'd3
`define G_DEB      3'd4
`define G_GK       3'd5
`define NGREG      6
`define HWY_BIT    7
`define TAB_BIT    7
`define HIGHWAY_SIGNALING_SELECT_BIT  5
`define CHANNEL_ACTIVE_FLAG_BIT  7
`define CFG_RST    8'h9a
`define CHEN_RST   8'h0f
`define ZERO_RST   8'h00

// ----------------------------------------------------------------------
// Frame counts
// ----------------------------------------------------------------------
`define MIN_EDGES  5'd8
`define RST_EDGES  5'd16
`define FS_VALID   2'd2

`endif

// *** rtl/qsp_pkg.sv ***
package qsp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WDAT, ST_RDAT} qsp_state_e;
  typedef enum logic [2:0] {
    K_NONE, K_CTL, K_CREG, K_GREG, K_COEF, K_RTD, K_REV, K_TXPCM
  } qsp_kind_e;
  typedef struct packed {
    qsp_kind_e  kind;
    logic [2:0] idx;
    logic [3:0] len;
  } qsp_dec_s;
endpackage : qsp_pkg

// *** rtl/qsp_link_if.sv ***
`timescale 1ns/100ps
interface qsp_link_if (input wire logic sclk);
  logic       cs_n;
  logic       sdi;
  logic       clr;
  logic [4:0] edge_cnt;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic       sdo;
  modport link (input sclk, cs_n, sdi, clr, tx_byte,
                output edge_cnt, rx_byte, sdo);
  modport core (input edge_cnt, rx_byte, sdo,
                output cs_n, sdi, clr, tx_byte);
endinterface : qsp_link_if

// *** rtl/qsp_link.sv ***
`timescale 1ns/100ps
`include "qsp_consts.svh"
module qsp_link (
  qsp_link_if.link lk
);
  logic [4:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [2:0] fall_reg;

  // --------------------------------------------------------------------
  // Capture on rising edges, only while selected
  // --------------------------------------------------------------------
  // Edges with chip-select high never touch state, so a shared clock is
  // harmless and the captured values stay still for the core to read.
  always_ff @(posedge lk.sclk or posedge lk.clr) begin
    if (lk.clr) begin
      cnt_reg <= 5'd0;
      sh_reg  <= 8'h00;
    end else if (!lk.cs_n) begin
      sh_reg <= {sh_reg[6:0], lk.sdi};
      if (cnt_reg != `RST_EDGES) begin
        cnt_reg <= cnt_reg + 5'd1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Output bit index advances on falling edges
  // --------------------------------------------------------------------
  // Clock idles high, so a frame opens with a falling edge; only falls
  // after a sample advance, else the MSB would be gone before it is read.
  always_ff @(negedge lk.sclk or posedge lk.clr) begin
    if (lk.clr) begin
      fall_reg <= 3'd0;
    end else if (!lk.cs_n && cnt_reg != 5'd0 && fall_reg != 3'd7) begin
      fall_reg <= fall_reg + 3'd1;
    end
  end

  assign lk.edge_cnt = cnt_reg;
  assign lk.rx_byte  = sh_reg;
  // MSB stands before any clock edge of the frame
  assign lk.sdo      = lk.tx_byte[3'd7 - fall_reg];
endmodule : qsp_link

// *** rtl/qsp_port.sv ***
`timescale 1ns/100ps
`include "qsp_consts.svh"
// Overview of operation
// - Frames with under 8 rising clock edges are dropped, nothing changes.
// - Frames with 8 to 15 edges use the last eight bits as byte.
// - Frames with 16 or more edges cause a full hardware reset.
// - Shift clock activity while deselected alters nothing.
// - Clock parked high keeps all state and partial command sequences.
// - Pending read drives its next bit two to three CLK_IN cycles after chip-select falls.
// - Register opcodes pair even write with odd read.
// - Filter coefficient write/read opcode pairs are decoded.
// - Mask, revision, debounce, PCM data and ground-key opcodes decoded.
// - Real-time read 4D keeps the interrupt; 4F also clears it.
// - Host writes reserved bits as zero; readback need not be zero.
// - Hardware reset forces every register to its default.
// - Deactivate puts enabled channels in standby, settings kept.
// - Standby floats PCM outputs unless highway signaling is selected.
// - Deactivate clears the channel active flag.
// - Software reset resets enabled channels, keeping slots and globals.
// - Hardware reset opcode acts like the reset pin for all channels.
// - Activate puts enabled channels active and sets the active flag.
// - No valid transmit data until the second frame sync after activate.
// - Transmit slot byte bits 6..0 hold the slot number 0-127.
// - Transmit slot bit 7 selects highway B; both-highways overrides.
// - Single-highway variants have no highway B.
// - Bytes go MSB first, one chip-select low period each.
// - No command is taken until all read bytes are shifted out.
// - Writes go to all enabled channels; reads from the lowest one.
module qsp_port #(
  parameter int         NCH      = 4,
  parameter bit         DUAL_HWY = 1'b1,
  parameter logic [7:0] REV_CODE = 8'h5a  // arbitrary value
) (
  input  wire logic           CLK_IN,
  input  wire logic           RESETN_IN,
  input  wire logic           SERIAL_SHIFT_CLOCK_IN,
  input  wire logic           SCS_N_IN,
  input  wire logic           SERIAL_DATA_LINE_IN,
  input  wire logic           FRAME_SYNC_PULSE_IN,
  input  wire logic [7:0]     RTD_IN,
  output logic                SERIAL_DATA_LINE_OUT,
  output logic                SERIAL_DATA_LINE_OE_OUT,
  output logic                INT_OUT,
  output logic [NCH-1:0]      CH_ACTIVE_OUT,
  output logic [NCH-1:0]      CH_PCM_FLOAT_OUT,
  output logic [NCH-1:0]      CH_TX_VALID_OUT,
  output logic [NCH-1:0]      TX_HWY_B_OUT
);
  import qsp_pkg::*;

  qsp_link_if lk (.sclk(SERIAL_SHIFT_CLOCK_IN));
  qsp_link u_link (.lk(lk));

  logic       cs_m1_reg, cs_s_reg, cs_d_reg;
  logic       fs_m1_reg, fs_s_reg, fs_d_reg;
  logic [7:0] rtd_m1_reg, rtd_s_reg, rtd_d_reg;
  logic       clr_reg;
  qsp_state_e state_reg;
  qsp_kind_e  kind_reg;
  logic [2:0] idx_reg;
  logic [3:0] rem_reg;
  logic [7:0] tx_byte_reg;
  logic       oe_reg;
  logic       int_reg;
  logic [7:0] creg_reg [NCH][`NCREG];
  logic [7:0] greg_reg [`NGREG];
  logic [NCH-1:0] act_reg;
  logic [1:0] fsc_reg [NCH];
  logic [NCH-1:0] float_reg, txv_reg, hwyb_reg;

  logic       frame_end, got_byte, long_frame, cmd_ok, hw_rst;
  logic [7:0] rxb;
  logic [4:0] cnt;
  qsp_dec_s   dec;
  logic [NCH-1:0] chen;
  logic [1:0] first_ch;
  logic [7:0] rd_first;
  logic       rtd_event;

  // --------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------
  function automatic qsp_dec_s decode(input logic [7:0] op);
    qsp_dec_s d;
    d = '{K_NONE, 3'd0, 4'd0};
    case (op & `OP_RW_MASK)
      `OP_TXS:  d = '{K_CREG, `C_TXS, `LEN_ONE};
      `OP_RXS:  d = '{K_CREG, `C_RXS, `LEN_ONE};
      `OP_AISN: d = '{K_CREG, `C_AISN, `LEN_ONE};
      `OP_SIO:  d = '{K_CREG, `C_SIO, `LEN_ONE};
      `OP_SDIR: d = '{K_CREG, `C_SDIR, `LEN_ONE};
      `OP_OPF:  d = '{K_CREG, `C_OPF, `LEN_ONE};
      `OP_OPC:  d = '{K_CREG, `C_OPC, `LEN_ONE};
      `OP_CLKS: d = '{K_GREG, `G_CLKS, `LEN_ONE};
      `OP_CFG:  d = '{K_GREG, `G_CFG, `LEN_ONE};
      `OP_CHEN: d = '{K_GREG, `G_CHEN, `LEN_ONE};
      `OP_IMSK: d = '{K_GREG, `G_IMSK, `LEN_ONE};
      `OP_DEB:  d = '{K_GREG, `G_DEB, `LEN_ONE};
      `OP_GK:   d = '{K_GREG, `G_GK, `LEN_ONE};
      `OP_GX:   d = '{K_COEF, 3'd0, `LEN_GX};
      `OP_GR:   d = '{K_COEF, 3'd0, `LEN_GR};
      `OP_ZC:   d = '{K_COEF, 3'd0, `LEN_ZC};
      `OP_B1:   d = '{K_COEF, 3'd0, `LEN_B1};
      `OP_XF:   d = '{K_COEF, 3'd0, `LEN_XF};
      `OP_RF:   d = '{K_COEF, 3'd0, `LEN_RF};
      `OP_B2:   d = '{K_COEF, 3'd0, `LEN_B2};
      `OP_ZF:   d = '{K_COEF, 3'd0, `LEN_ZF};
      `OP_ZI:   d = '{K_COEF, 3'd0, `LEN_ZI};
      default:  d = '{K_NONE, 3'd0, 4'd0};
    endcase
    case (op)
      `OP_DEACT, `OP_SRST, `OP_HRST, `OP_NOP, `OP_ACT:
        d = '{K_CTL, 3'd0, 4'd0};
      `OP_RTD, `OP_RTDC: d = '{K_RTD, 3'd0, `LEN_ONE};
      `OP_REV:   d = '{K_REV, 3'd0, `LEN_ONE};
      `OP_TXPCM: d = '{K_TXPCM, 3'd0, `LEN_ONE};
      default: d = d;
    endcase
    return d;
  endfunction : decode

  function automatic logic [1:0] lowest(input logic [NCH-1:0] en);
    logic [1:0] r;
    r = 2'd0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (en[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : lowest

  function automatic logic [7:0] c_dflt(input int ch, input int idx);
    logic [7:0] v;
    v = `ZERO_RST;
    if (idx == int'(`C_TXS) || idx == int'(`C_RXS)) begin
      v = 8'(ch);
    end
    return v;
  endfunction : c_dflt

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cs_m1_reg  <= 1'b1;
      cs_s_reg   <= 1'b1;
      cs_d_reg   <= 1'b1;
      fs_m1_reg  <= 1'b0;
      fs_s_reg   <= 1'b0;
      fs_d_reg   <= 1'b0;
      rtd_m1_reg <= 8'h00;
      rtd_s_reg  <= 8'h00;
      rtd_d_reg  <= 8'h00;
    end else begin
      cs_m1_reg  <= SCS_N_IN;
      cs_s_reg   <= cs_m1_reg;
      cs_d_reg   <= cs_s_reg;
      fs_m1_reg  <= FRAME_SYNC_PULSE_IN;
      fs_s_reg   <= fs_m1_reg;
      fs_d_reg   <= fs_s_reg;
      rtd_m1_reg <= RTD_IN;
      rtd_s_reg  <= rtd_m1_reg;
      rtd_d_reg  <= rtd_s_reg;
    end
  end

  // --------------------------------------------------------------------
  // Frame qualification
  // --------------------------------------------------------------------
  // Link values are read only after chip-select rose, when they are still.
  assign rxb        = lk.rx_byte;
  assign cnt        = lk.edge_cnt;
  assign frame_end  = cs_s_reg & ~cs_d_reg;
  assign got_byte   = frame_end & (cnt >= `MIN_EDGES)
                    & (cnt < `RST_EDGES);
  assign long_frame = frame_end & (cnt == `RST_EDGES);
  assign cmd_ok     = got_byte & (state_reg == ST_IDLE);
  assign dec        = decode(rxb);
  assign hw_rst     = long_frame
                    | (cmd_ok & (rxb == `OP_HRST));
  assign chen       = greg_reg[`G_CHEN][NCH-1:0];
  assign first_ch   = lowest(chen);
  assign rtd_event  = |((rtd_s_reg ^ rtd_d_reg) & ~greg_reg[`G_IMSK]);

  assign lk.cs_n    = SCS_N_IN;
  assign lk.sdi     = SERIAL_DATA_LINE_IN;
  assign lk.clr     = clr_reg;
  assign lk.tx_byte = tx_byte_reg;

  always_comb begin
    rd_first = 8'h00;
    case (dec.kind)
      K_CREG: begin
        rd_first = creg_reg[first_ch][dec.idx];
        if (dec.idx == `C_SDIR) begin
          rd_first[`CHANNEL_ACTIVE_FLAG_BIT] = act_reg[first_ch];
        end
      end
      K_GREG:  rd_first = greg_reg[dec.idx];
      K_RTD:   rd_first = rtd_s_reg;
      K_REV:   rd_first = REV_CODE;
      default: rd_first = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Link clear, pulsed while deselected after each frame
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      clr_reg <= 1'b1;
    end else begin
      clr_reg <= frame_end;
    end
  end

  // --------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------
  // State moves only on a qualified frame end, so idle gaps of any length
  // keep a partial sequence.
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_reg   <= ST_IDLE;
      kind_reg    <= K_NONE;
      idx_reg     <= 3'd0;
      rem_reg     <= 4'd0;
      tx_byte_reg <= 8'h00;
    end else if (hw_rst) begin
      state_reg   <= ST_IDLE;
      rem_reg     <= 4'd0;
      tx_byte_reg <= 8'h00;
    end else if (cmd_ok && dec.len != 4'd0) begin
      kind_reg <= dec.kind;
      idx_reg  <= dec.idx;
      rem_reg  <= dec.len;
      if (rxb[0]) begin
        state_reg   <= ST_RDAT;
        tx_byte_reg <= rd_first;
      end else begin
        state_reg <= ST_WDAT;
      end
    end else if (got_byte && state_reg != ST_IDLE) begin
      rem_reg     <= rem_reg - 4'd1;
      tx_byte_reg <= 8'h00;
      if (rem_reg == 4'd1) begin
        state_reg <= ST_IDLE;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= (state_reg == ST_RDAT) & ~cs_s_reg;
    end
  end

  // --------------------------------------------------------------------
  // Register store
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < `NGREG; i++) begin
        greg_reg[i] <= `ZERO_RST;
      end
      greg_reg[`G_CFG]  <= `CFG_RST;
      greg_reg[`G_CHEN] <= `CHEN_RST;
    end else if (hw_rst) begin
      for (int i = 0; i < `NGREG; i++) begin
        greg_reg[i] <= `ZERO_RST;
      end
      greg_reg[`G_CFG]  <= `CFG_RST;
      greg_reg[`G_CHEN] <= `CHEN_RST;
    end else if (got_byte && state_reg == ST_WDAT && kind_reg == K_GREG) begin
      greg_reg[idx_reg] <= rxb;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int c = 0; c < NCH; c++) begin
        for (int i = 0; i < `NCREG; i++) begin
          creg_reg[c][i] <= c_dflt(c, i);
        end
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        for (int i = 0; i < `NCREG; i++) begin
          if (hw_rst) begin
            creg_reg[c][i] <= c_dflt(c, i);
          end else if (cmd_ok && rxb == `OP_SRST && chen[c]
                       && i != int'(`C_TXS) && i != int'(`C_RXS)) begin
            creg_reg[c][i] <= c_dflt(c, i);
          end else if (got_byte && state_reg == ST_WDAT
                       && kind_reg == K_CREG && chen[c]
                       && idx_reg == 3'(i)) begin
            creg_reg[c][i] <= rxb;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Channel state
  // --------------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        act_reg[g] <= 1'b0;
        fsc_reg[g] <= 2'd0;
      end else if (hw_rst) begin
        act_reg[g] <= 1'b0;
        fsc_reg[g] <= 2'd0;
      end else if (cmd_ok && chen[g] && rxb == `OP_ACT) begin
        act_reg[g] <= 1'b1;
        fsc_reg[g] <= 2'd0;
      end else if (cmd_ok && chen[g]
                   && (rxb == `OP_DEACT || rxb == `OP_SRST)) begin
        act_reg[g] <= 1'b0;
      end else if (fs_s_reg && !fs_d_reg && act_reg[g]
                   && fsc_reg[g] != `FS_VALID) begin
        fsc_reg[g] <= fsc_reg[g] + 2'd1;
      end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        float_reg[g] <= 1'b1;
        txv_reg[g]   <= 1'b0;
        hwyb_reg[g]  <= 1'b0;
      end else begin
        float_reg[g] <= ~act_reg[g]
                      & ~greg_reg[`G_CFG][`HIGHWAY_SIGNALING_SELECT_BIT];
        txv_reg[g]   <= act_reg[g] & (fsc_reg[g] == `FS_VALID);
        hwyb_reg[g]  <= DUAL_HWY
                      & (creg_reg[g][`C_TXS][`HWY_BIT]
                      | greg_reg[`G_CLKS][`TAB_BIT]);
      end
    end
  end

  // --------------------------------------------------------------------
  // Real-time data interrupt; a new event beats a clearing read
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      int_reg <= 1'b0;
    end else if (hw_rst) begin
      int_reg <= 1'b0;
    end else if (rtd_event) begin
      int_reg <= 1'b1;
    end else if (cmd_ok && rxb == `OP_RTDC) begin
      int_reg <= 1'b0;
    end
  end

  assign SERIAL_DATA_LINE_OUT    = lk.sdo;
  assign SERIAL_DATA_LINE_OE_OUT = oe_reg;
  assign INT_OUT                 = int_reg;
  assign CH_ACTIVE_OUT           = act_reg;
  assign CH_PCM_FLOAT_OUT        = float_reg;
  assign CH_TX_VALID_OUT         = txv_reg;
  assign TX_HWY_B_OUT            = hwyb_reg;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  short_frame_a: assert property (frame_end && cnt < `MIN_EDGES
    |=> state_reg == $past(state_reg) && act_reg == $past(act_reg))
    else $error("short frame changed state");
  byte_act_a: assert property (cmd_ok && rxb == `OP_ACT && chen[0]
    |=> act_reg[0] ##1 CH_ACTIVE_OUT[0])
    else $error("activate byte not applied");
  long_frame_a: assert property (long_frame
    |=> state_reg == ST_IDLE && greg_reg[`G_CHEN] == `CHEN_RST
        && !act_reg[0])
    else $error("long frame did not reset");
  cs_high_hold_a: assert property (cs_s_reg && cs_d_reg
    |=> $stable(state_reg) && $stable(rem_reg))
    else $error("state moved while deselected");
  read_drive_a: assert property (state_reg == ST_RDAT && !cs_s_reg
    |=> SERIAL_DATA_LINE_OE_OUT)
    else $error("read byte not driven");
  tx_slot_rd_a: assert property (cmd_ok && rxb == (`OP_TXS | 8'h01)
    |=> state_reg == ST_RDAT
        && tx_byte_reg == creg_reg[first_ch][`C_TXS])
    else $error("slot read wrong");
  rtd_keep_a: assert property (cmd_ok && rxb == `OP_RTD && int_reg
    |=> int_reg)
    else $error("plain read cleared interrupt");
  rtd_clear_a: assert property (cmd_ok && rxb == `OP_RTDC
    && !rtd_event |=> !int_reg ##1 !INT_OUT || $past(rtd_event))
    else $error("clearing read kept interrupt");
  deact_a: assert property (cmd_ok && rxb == `OP_DEACT && chen[0]
    |=> !act_reg[0] ##2 CH_PCM_FLOAT_OUT[0]
        == !greg_reg[`G_CFG][`HIGHWAY_SIGNALING_SELECT_BIT] || act_reg[0])
    else $error("deactivate failed");
  tx_valid_a: assert property (CH_TX_VALID_OUT[0]
    |-> $past(fsc_reg[0]) == `FS_VALID)
    else $error("early valid transmit");
  rd_busy_a: assert property (state_reg == ST_RDAT && got_byte
    && rem_reg > 4'd1 |=> state_reg == ST_RDAT)
    else $error("read ended early");
endmodule : qsp_port

// *** dv/qsp_host_model.sv ***
`timescale 1ns/100ps
module qsp_host_model (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      dat_out,
  input  wire logic dat_in
);
  logic [15:0] rx_sr     = 16'h0000;
  logic        first_bit = 1'b0;
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    dat_out  = 1'b0;
  end
  // --------------------------------------------------------------
  // Frames: clock parked high outside them
  // --------------------------------------------------------------
  task automatic frame(input int n, input logic [15:0] bits);
    cs_n_out = 1'b0;
    #40;
    first_bit = dat_in;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out = 1'b0;
      dat_out  = bits[i];
      #6;
      sclk_out = 1'b1;
      rx_sr    = {rx_sr[14:0], dat_in};
      #6;
    end
    cs_n_out = 1'b1;
    // Released line must not keep its last level
    dat_out  = ~dat_out;
    #100;
  endtask : frame
  // Shared clock running while deselected
  task automatic idle_clock(input int n);
    repeat (n) begin
      sclk_out = 1'b0;
      dat_out  = ~dat_out;
      #6;
      sclk_out = 1'b1;
      #6;
    end
  endtask : idle_clock
endmodule : qsp_host_model

// *** dv/qsp_port_tb_top.sv ***
`timescale 1ns/100ps
module qsp_port_tb_top;
  localparam logic [7:0] REV = 8'h3c;  // arbitrary value
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       fs = 1'b0;
  logic [7:0] rtd = 8'h00;
  wire        sclk, cs_n, hdat;
  logic       dout, doe, irq;
  logic [3:0] act, flt, txv, hwy;
  wire        line = doe ? dout : hdat;
  int         err_count = 0;
  int         check_count = 0;
  logic [7:0] b, got;
  always #5 clk = ~clk;
  qsp_host_model qsp_host_model_inst (.sclk_out(sclk), .cs_n_out(cs_n),
    .dat_out(hdat), .dat_in(line));
  qsp_port #(.REV_CODE(REV)) qsp_port_inst (.CLK_IN(clk),
    .RESETN_IN(rst_n), .SERIAL_SHIFT_CLOCK_IN(sclk), .SCS_N_IN(cs_n),
    .SERIAL_DATA_LINE_IN(line), .FRAME_SYNC_PULSE_IN(fs), .RTD_IN(rtd),
    .SERIAL_DATA_LINE_OUT(dout), .SERIAL_DATA_LINE_OE_OUT(doe),
    .INT_OUT(irq), .CH_ACTIVE_OUT(act), .CH_PCM_FLOAT_OUT(flt),
    .CH_TX_VALID_OUT(txv), .TX_HWY_B_OUT(hwy));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [3:0] all_ch(input logic v);
    return {4{v}};
  endfunction : all_ch
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      err_count++;
    end
  endtask : chk
  task automatic send(input logic [7:0] v);
    // Defined opcodes and data bytes, bar one deliberate reserved-code probe
    qsp_host_model_inst.frame(8, {8'h00, v});
  endtask : send
  task automatic rd(output logic [7:0] v);
    qsp_host_model_inst.frame(8, 16'h5555);
    v = qsp_host_model_inst.rx_sr[7:0];
  endtask : rd
  task automatic fs_pulse();
    @(negedge clk) fs = 1'b1;
    repeat (2) @(negedge clk);
    fs = 1'b0;
    repeat (4) @(negedge clk);
  endtask : fs_pulse
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(32'h24d6efca));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    qsp_host_model_inst.idle_clock(20);
    chk({act, flt, txv, hwy, doe, irq}, 18'h03c00);
    send(8'h0e);
    chk(act, 4'hf);
    fs_pulse();
    chk(txv, 4'h0);
    fs_pulse();
    chk(txv, 4'hf);
    repeat (4) begin
      b = 8'($urandom);
      send(8'h40);
      qsp_host_model_inst.frame(5, 16'($urandom));
      send(b);
      chk(hwy, all_ch(b[7]));
      send(8'h41);
      rd(got);
      chk(got, b);
      chk(qsp_host_model_inst.first_bit, b[7]);
    end
    @(negedge clk) rtd = 8'($urandom) | 8'h01;
    repeat (10) @(negedge clk);
    chk(irq, 1'b1);
    send(8'h4d);
    rd(got);
    chk({got, irq}, {rtd, 1'b1});
    send(8'h4f);
    rd(got);
    chk({got, irq}, {rtd, 1'b0});
    send(8'h73);
    rd(got);
    chk(got, REV);
    send(8'h06);
    send(8'h07);
    chk({act, hwy}, {4'hf, all_ch(b[7])});
    qsp_host_model_inst.frame(12, 16'h0f00);
    chk({act, flt}, 8'h0f);
    send(8'h0e);
    send(8'h02);
    chk({act, hwy}, {4'h0, all_ch(b[7])});
    send(8'h4a);
    send(8'h01);
    send(8'h0e);
    chk(act, 4'h1);
    for (int k = 0; k < 2; k++) begin
      send(8'h40);
      send(8'h80);
      if (k == 0)
        send(8'h04);
      else
        qsp_host_model_inst.frame(16, 16'($urandom));
      chk({act, hwy, flt}, 12'h00f);
      send(8'h0e);
      chk(act, 4'hf);
    end
    end_of_test();
  end
endmodule : qsp_port_tb_top
